// ---- can_rx_interrupt_enable_tb.sv ----
// self-checking testbench for the receiver interrupt enable block
`timescale 1ns/100ps
module can_rx_interrupt_enable_tb
   import crie_pkg::*;
;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        clk_i;
   logic        rst_i;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   crie_evt_t   evt_i;
   logic        init_mode_acknowledge_i;
   logic [7:0]  receive_error_level_i;
   logic [8:0]  transmit_error_level_i;
   logic        init_mode_request_o;
   logic        wake_function_enable_o;
   crie_irq_t   irq_req_o;
   logic        irq_o;
   int          failures;
   int          compares;
   logic [7:0]  exp_q[$];
   logic [15:0] lfsr;
   logic [2:0]  evt_tab [3] = '{3'h4, 3'h2, 3'h1};
   logic [2:0]  irq_tab [3] = '{3'h4, 3'h1, 3'h2};
   int          bit_tab [3] = '{BIT_WAKE, BIT_RXF, BIT_OVR};

   crie_top crie_top_inst (
      .clk_i                   (clk_i),
      .rst_i                   (rst_i),
      .wb_cyc_i                (wb_cyc_i),
      .wb_stb_i                (wb_stb_i),
      .wb_we_i                 (wb_we_i),
      .wb_adr_i                (wb_adr_i),
      .wb_sel_i                (wb_sel_i),
      .wb_dat_i                (wb_dat_i),
      .wb_dat_o                (wb_dat_o),
      .wb_ack_o                (wb_ack_o),
      .evt_i                   (evt_i),
      .init_mode_acknowledge_i (init_mode_acknowledge_i),
      .receive_error_level_i   (receive_error_level_i),
      .transmit_error_level_i  (transmit_error_level_i),
      .init_mode_request_o     (init_mode_request_o),
      .wake_function_enable_o  (wake_function_enable_o),
      .irq_req_o               (irq_req_o),
      .irq_o                   (irq_o)
   );

   always #10 clk_i = ~clk_i;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // classic cycle: hold everything until ack is sampled, then release
   task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h000000, dat};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      check("bus ack", {31'h0, wb_ack_o}, 32'h1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      wb(1'b1, adr, dat);
   endtask

   task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
      exp_q.push_back(exp);
      wb(1'b0, adr, 8'h00);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic pulse(input logic [2:0] e);
      @(posedge clk_i);
      evt_i <= e;
      @(posedge clk_i);
      evt_i <= '0;
      tick(2);
   endtask

   task automatic finish_test;
      check("pending reads", exp_q.size(), 32'h0);
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // read data monitor: oldest note against each read answer
   // ----------------------------------------------------------------
   always @(posedge clk_i)
   begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && wb_cyc_i === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("unexpected read", 32'h1, 32'h0);
         else
            check("read data", wb_dat_o, {24'h000000, exp_q.pop_front()});
      end
   end

   // hang guard: the whole run needs well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge clk_i);
      check("watchdog", 32'h1, 32'h0);
      finish_test;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h00000000;
      evt_i = '0;
      init_mode_acknowledge_i = 1'b0;
      receive_error_level_i = 8'h00;
      transmit_error_level_i = 9'h000;
      failures = 0;
      compares = 0;
      lfsr = 16'hD4FB;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      check("irq after reset", {31'h0, irq_o}, 32'h0);
      rd(ADR_RX_IRQ_ENABLE, EN_RESET);
      rd(ADR_RX_FLAGS, FLAG_RESET);
      rd(ADR_CTRL, 8'h00);
      wr(8'h0C, 8'hFF);
      rd(8'h0C, 8'h00);
      $display("test reset done");
      for (int k = 0; k < 6; k++)
      begin
         lfsr = lfsr_next(lfsr);
         wr(ADR_RX_IRQ_ENABLE, lfsr[7:0]);
         rd(ADR_RX_IRQ_ENABLE, lfsr[7:0]);
      end
      $display("test enable access done");
      // wake flag needs the wake function, so an early wake event is dropped
      wr(ADR_RX_IRQ_ENABLE, 8'h00);
      pulse(3'h4);
      rd(ADR_RX_FLAGS, 8'h00);
      wr(ADR_CTRL, 8'h02);
      check("wake function", {31'h0, wake_function_enable_o}, 32'h1);
      for (int k = 0; k < 3; k++)
      begin
         wr(ADR_RX_IRQ_ENABLE, 8'h00);
         pulse(evt_tab[k]);
         check("masked request", {29'h0, irq_req_o}, 32'h0);
         // the host only looks at the flags, it never touches a receive buffer
         rd(ADR_RX_FLAGS, 8'h01 << bit_tab[k]);
         wr(ADR_RX_IRQ_ENABLE, 8'h01 << bit_tab[k]);
         tick(2);
         check("unmasked request", {29'h0, irq_req_o}, {29'h0, irq_tab[k]});
         check("irq line", {31'h0, irq_o}, 32'h1);
         wr(ADR_RX_FLAGS, 8'h01 << bit_tab[k]);
         tick(2);
         check("irq cleared", {31'h0, irq_o}, 32'h0);
      end
      $display("test event gating done");
      wr(ADR_RX_IRQ_ENABLE, 8'h70);
      receive_error_level_i <= 8'h64;
      tick(3);
      rd(ADR_RX_FLAGS, 8'h50);
      check("status request", {29'h0, irq_req_o}, 32'h2);
      receive_error_level_i <= 8'hC8;
      tick(3);
      rd(ADR_RX_FLAGS, 8'h50);
      wr(ADR_RX_FLAGS, 8'h40);
      tick(2);
      rd(ADR_RX_FLAGS, 8'h60);
      wr(ADR_RX_IRQ_ENABLE, 8'h44);
      receive_error_level_i <= 8'h00;
      wr(ADR_RX_FLAGS, 8'h40);
      tick(2);
      rd(ADR_RX_FLAGS, 8'h00);
      transmit_error_level_i <= 9'h064;
      tick(3);
      rd(ADR_RX_FLAGS, 8'h04);
      transmit_error_level_i <= 9'h12C;
      tick(3);
      rd(ADR_RX_FLAGS, 8'h7C);
      check("bus-off request", {29'h0, irq_req_o}, 32'h2);
      $display("test state change done");
      wr(ADR_RX_IRQ_ENABLE, 8'hFF);
      wr(ADR_CTRL, 8'h01);
      check("init request", {31'h0, init_mode_request_o}, 32'h1);
      wr(ADR_RX_IRQ_ENABLE, 8'h00);
      rd(ADR_RX_IRQ_ENABLE, 8'hFF);
      init_mode_acknowledge_i <= 1'b1;
      tick(2);
      rd(ADR_RX_IRQ_ENABLE, EN_INIT_KEEP);
      rd(ADR_CTRL, 8'h05);
      wr(ADR_RX_IRQ_ENABLE, 8'h00);
      rd(ADR_RX_IRQ_ENABLE, EN_INIT_KEEP);
      init_mode_acknowledge_i <= 1'b0;
      wr(ADR_CTRL, 8'h00);
      wr(ADR_RX_IRQ_ENABLE, 8'h81);
      rd(ADR_RX_IRQ_ENABLE, 8'h81);
      $display("test init mode done");
      // code 10 on both sides: a step from err into bus-off must still raise the flag
      receive_error_level_i <= 8'hC8;
      transmit_error_level_i <= 9'h096;
      wr(ADR_RX_IRQ_ENABLE, 8'h68);
      wr(ADR_RX_FLAGS, 8'h40);
      tick(2);
      rd(ADR_RX_FLAGS, 8'h68);
      wr(ADR_RX_FLAGS, 8'h40);
      tick(2);
      rd(ADR_RX_FLAGS, 8'h28);
      transmit_error_level_i <= 9'h12C;
      tick(3);
      rd(ADR_RX_FLAGS, 8'h7C);
      check("err level request", {29'h0, irq_req_o}, 32'h2);
      $display("test sensitivity level done");
      tick(2);
      finish_test;
   end
endmodule // can_rx_interrupt_enable_tb

// ---- crie_pkg.sv ----
// package: offsets, field layout, reset values and encodings of the receiver interrupt enable block
package crie_pkg;

   // ----------------------------------------------------------------
   // register byte addresses (aligned words)
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADR_RX_IRQ_ENABLE = 8'h00;
   localparam logic [7:0]  ADR_RX_FLAGS      = 8'h04;
   localparam logic [7:0]  ADR_CTRL          = 8'h08;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned BIT_WAKE      = 7;
   localparam int unsigned BIT_CSC       = 6;
   localparam int unsigned RSENS_HI      = 5;
   localparam int unsigned RSENS_LO      = 4;
   localparam int unsigned TSENS_HI      = 3;
   localparam int unsigned TSENS_LO      = 2;
   localparam int unsigned BIT_OVR       = 1;
   localparam int unsigned BIT_RXF       = 0;
   localparam int unsigned CTRL_INIT_REQ = 0;
   localparam int unsigned CTRL_WAKE_FN  = 1;
   localparam int unsigned CTRL_INIT_ACK = 2;

   // ----------------------------------------------------------------
   // reset values and masks
   // ----------------------------------------------------------------
   localparam logic [7:0]  EN_RESET      = 8'h00;
   localparam logic [7:0]  EN_INIT_KEEP  = 8'h3C;
   localparam logic [7:0]  FLAG_RESET    = 8'h00;
   localparam logic [7:0]  FLAG_MASK     = 8'hC3;
   localparam logic [1:0]  CTRL_RESET    = 2'h0;

   // ----------------------------------------------------------------
   // error counter limits and state codes
   // ----------------------------------------------------------------
   localparam logic [8:0]  WARN_LIMIT    = 9'h060;
   localparam logic [8:0]  ERR_LIMIT     = 9'h07F;
   localparam logic [8:0]  BUSOFF_LIMIT  = 9'h0FF;
   localparam logic [1:0]  ST_OK         = 2'h0;
   localparam logic [1:0]  ST_WARN       = 2'h1;
   localparam logic [1:0]  ST_ERR        = 2'h2;
   localparam logic [1:0]  ST_BUSOFF     = 2'h3;
   localparam logic [1:0]  SENS_NONE     = 2'h0;
   localparam logic [1:0]  SENS_BUSOFF   = 2'h1;
   localparam logic [1:0]  SENS_ERR      = 2'h2;
   localparam logic [1:0]  SENS_ALL      = 2'h3;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wake_activity;
      logic msg_stored;
      logic overrun;
   } crie_evt_t;

   typedef struct packed {
      logic wake;
      logic err;
      logic rx;
   } crie_irq_t;

endpackage

// ---- crie_sens_filter.sv ----
// sensitivity filter: decides whether a state change should raise the status-change flag
`timescale 1ns/100ps
module crie_sens_filter
   import crie_pkg::*;
(
   input  wire logic [1:0] sens_i,
   input  wire logic [1:0] old_state_i,
   input  wire logic [1:0] new_state_i,
   output logic            hit_o
);

   logic busoff_cross;
   logic err_cross;

   // ----------------------------------------------------------------
   // filter
   // ----------------------------------------------------------------
   always_comb
   begin
      busoff_cross = (old_state_i == ST_BUSOFF) != (new_state_i == ST_BUSOFF);
      // any move that touches err or bus-off counts, so a step from err into bus-off is not dropped
      err_cross    = (old_state_i != new_state_i) && ((old_state_i >= ST_ERR) || (new_state_i >= ST_ERR));
      unique case (sens_i)
         SENS_NONE:   hit_o = 1'b0;
         SENS_BUSOFF: hit_o = busoff_cross;
         SENS_ERR:    hit_o = err_cross;
         SENS_ALL:    hit_o = old_state_i != new_state_i;
      endcase
   end

endmodule // crie_sens_filter

// ---- crie_state_enc.sv ----
// error counter to receiver and transmitter error state encoder
`timescale 1ns/100ps
module crie_state_enc
   import crie_pkg::*;
(
   input  wire logic [7:0] receive_error_level_i,
   input  wire logic [8:0] transmit_error_level_i,
   output logic      [1:0] rx_state_o,
   output logic      [1:0] tx_state_o
);

   logic [8:0] rec_w;

   assign rec_w = {1'b0, receive_error_level_i};

   // ----------------------------------------------------------------
   // encoding
   // ----------------------------------------------------------------
   always_comb
   begin
      // bus-off of the transmitter overrides the receiver state
      if (transmit_error_level_i > BUSOFF_LIMIT)
         rx_state_o = ST_BUSOFF;
      else if (rec_w > ERR_LIMIT)
         rx_state_o = ST_ERR;
      else if (rec_w > WARN_LIMIT)
         rx_state_o = ST_WARN;
      else
         rx_state_o = ST_OK;
      if (transmit_error_level_i > BUSOFF_LIMIT)
         tx_state_o = ST_BUSOFF;
      else if (transmit_error_level_i > ERR_LIMIT)
         tx_state_o = ST_ERR;
      else if (transmit_error_level_i > WARN_LIMIT)
         tx_state_o = ST_WARN;
      else
         tx_state_o = ST_OK;
   end

endmodule // crie_state_enc

// ---- crie_top.sv ----
// receiver interrupt enable block with flags, error state tracking and wishbone slave
// Operation
// - during acknowledged init, enable register held at reset except sensitivity fields
// - enable writes accepted only with init neither requested nor acknowledged
// - sensitivity fields keep their programmed values through initialization mode
// - bit 7 gates the wake flag onto the wake interrupt request
// - bit 6 gates the status-change flag onto the error request
// - bits 5:4 choose which receiver state changes set the status-change flag
// - bits 3:2 choose which transmitter state changes set the status-change flag
// - state bits track real error state, updating only with no pending status change
// - bit 1 gates the overrun flag onto the error request
// - bit 0 gates the receive-full flag onto the receive request
// - state codes: 96, 127 counter limits, bus-off above 255 transmit errors
// - a pending status-change flag freezes the state bits until cleared
// - a stored matching message sets the receive-full flag
// - a data overrun sets the overrun flag
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
module crie_top
   import crie_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire crie_evt_t   evt_i,
   input  wire logic        init_mode_acknowledge_i,
   input  wire logic [7:0]  receive_error_level_i,
   input  wire logic [8:0]  transmit_error_level_i,
   output logic             init_mode_request_o,
   output logic             wake_function_enable_o,
   output crie_irq_t        irq_req_o,
   output logic             irq_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]  en_ff;
   logic [7:0]  nxt_en;
   logic [7:0]  flag_ff;
   logic [7:0]  nxt_flag;
   logic [1:0]  rx_state_ff;
   logic [1:0]  nxt_rx_state;
   logic [1:0]  tx_state_ff;
   logic [1:0]  nxt_tx_state;
   logic [1:0]  ctrl_ff;
   logic [1:0]  nxt_ctrl;
   logic        ack_ff;
   logic        nxt_ack;
   logic [31:0] dat_ff;
   logic [31:0] nxt_dat;
   crie_irq_t   req_ff;
   crie_irq_t   nxt_req;
   logic        irq_ff;
   logic        nxt_irq;

   logic [1:0]  rx_actual;
   logic [1:0]  tx_actual;
   logic        rx_hit;
   logic        tx_hit;
   logic        access;
   logic        wr_go;
   logic        init_active;
   logic        init_any;
   logic [7:0]  wr_byte;
   logic [7:0]  flag_rd;
   logic [7:0]  set_vec;
   logic [7:0]  clr_vec;

   assign wr_byte     = wb_dat_i[7:0];
   assign access      = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr_go       = access && wb_we_i && wb_sel_i[0];
   assign init_active = ctrl_ff[CTRL_INIT_REQ] && init_mode_acknowledge_i;
   assign init_any    = ctrl_ff[CTRL_INIT_REQ] || init_mode_acknowledge_i;
   assign flag_rd     = {flag_ff[BIT_WAKE], flag_ff[BIT_CSC], rx_state_ff, tx_state_ff,
                         flag_ff[BIT_OVR], flag_ff[BIT_RXF]};

   // ----------------------------------------------------------------
   // error state and sensitivity
   // ----------------------------------------------------------------
   crie_state_enc u_state_enc (
      .receive_error_level_i  (receive_error_level_i),
      .transmit_error_level_i (transmit_error_level_i),
      .rx_state_o             (rx_actual),
      .tx_state_o             (tx_actual)
   );

   crie_sens_filter u_rx_filter (
      .sens_i      (en_ff[RSENS_HI:RSENS_LO]),
      .old_state_i (rx_state_ff),
      .new_state_i (rx_actual),
      .hit_o       (rx_hit)
   );

   crie_sens_filter u_tx_filter (
      .sens_i      (en_ff[TSENS_HI:TSENS_LO]),
      .old_state_i (tx_state_ff),
      .new_state_i (tx_actual),
      .hit_o       (tx_hit)
   );

   // ----------------------------------------------------------------
   // registers and flags
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_en = en_ff;
      if (wr_go && (wb_adr_i == ADR_RX_IRQ_ENABLE) && !init_any)
         nxt_en = wr_byte;
      // init forcing comes last so it beats a blocked write anyway
      if (init_active)
         nxt_en = (en_ff & EN_INIT_KEEP) | (EN_RESET & ~EN_INIT_KEEP);

      set_vec = 8'h00;
      // wake activity only counts with the wake function on
      set_vec[BIT_WAKE] = evt_i.wake_activity && ctrl_ff[CTRL_WAKE_FN];
      set_vec[BIT_CSC]  = !flag_ff[BIT_CSC] && (rx_hit || tx_hit);
      set_vec[BIT_OVR]  = evt_i.overrun;
      set_vec[BIT_RXF]  = evt_i.msg_stored;
      clr_vec = 8'h00;
      if (wr_go && (wb_adr_i == ADR_RX_FLAGS))
         clr_vec = wr_byte & FLAG_MASK;
      // set wins over a clear in the same cycle
      nxt_flag = ((flag_ff & ~clr_vec) | set_vec) & FLAG_MASK;

      // frozen while a status change is pending, so software reads the cause
      nxt_rx_state = flag_ff[BIT_CSC] ? rx_state_ff : rx_actual;
      nxt_tx_state = flag_ff[BIT_CSC] ? tx_state_ff : tx_actual;

      nxt_ctrl = ctrl_ff;
      if (wr_go && (wb_adr_i == ADR_CTRL))
         nxt_ctrl = wr_byte[1:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         en_ff       <= EN_RESET;
         flag_ff     <= FLAG_RESET;
         rx_state_ff <= ST_OK;
         tx_state_ff <= ST_OK;
         ctrl_ff     <= CTRL_RESET;
      end
      else
      begin
         en_ff       <= nxt_en;
         flag_ff     <= nxt_flag;
         rx_state_ff <= nxt_rx_state;
         tx_state_ff <= nxt_tx_state;
         ctrl_ff     <= nxt_ctrl;
      end
   end

   // ----------------------------------------------------------------
   // interrupt requests
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_req.wake = flag_ff[BIT_WAKE] && en_ff[BIT_WAKE];
      nxt_req.err  = (flag_ff[BIT_CSC] && en_ff[BIT_CSC])
                     || (flag_ff[BIT_OVR] && en_ff[BIT_OVR]);
      nxt_req.rx   = flag_ff[BIT_RXF] && en_ff[BIT_RXF];
      nxt_irq      = |(flag_ff & en_ff & FLAG_MASK);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         req_ff <= '0;
         irq_ff <= 1'b0;
      end
      else
      begin
         req_ff <= nxt_req;
         irq_ff <= nxt_irq;
      end
   end

   // ----------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_ack = access;
      nxt_dat = 32'h0000_0000;
      // unmapped addresses still ack, reading zero, so a stray access never hangs the bus
      if (access && !wb_we_i)
      begin
         unique case (wb_adr_i)
            ADR_RX_IRQ_ENABLE: nxt_dat = {24'h00_0000, en_ff};
            ADR_RX_FLAGS:      nxt_dat = {24'h00_0000, flag_rd};
            ADR_CTRL:          nxt_dat = {29'h0000_0000, init_mode_acknowledge_i, ctrl_ff};
            default:           nxt_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end
      else
      begin
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
      end
   end

   assign wb_ack_o               = ack_ff;
   assign wb_dat_o               = dat_ff;
   assign init_mode_request_o    = ctrl_ff[CTRL_INIT_REQ];
   assign wake_function_enable_o = ctrl_ff[CTRL_WAKE_FN];
   assign irq_req_o              = req_ff;
   assign irq_o                  = irq_ff;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_en_write;
      wr_go && (wb_adr_i == ADR_RX_IRQ_ENABLE);
   endsequence

   sequence s_bus_req;
      wb_cyc_i && wb_stb_i && !ack_ff;
   endsequence

   a_init_hold_en: assert property (init_active |=> (en_ff & ~EN_INIT_KEEP) == 8'h00)
      else $error("enable bits not held at reset during init");

   a_init_keep_sens: assert property (init_active |=> en_ff[5:2] == $past(en_ff[5:2]))
      else $error("sensitivity fields changed by init");

   a_write_taken: assert property (s_en_write ##0 !init_any |=> en_ff == $past(wr_byte))
      else $error("enable write not taken");

   a_write_blocked: assert property (s_en_write ##0 (init_any && !init_active) |=> $stable(en_ff))
      else $error("enable write accepted during init");

   a_wake_gate: assert property (flag_ff[BIT_WAKE] && en_ff[BIT_WAKE] |=> irq_req_o.wake && irq_o)
      else $error("wake request missing");

   a_err_gate: assert property (!(flag_ff[BIT_CSC] && en_ff[BIT_CSC])
                                && !(flag_ff[BIT_OVR] && en_ff[BIT_OVR]) |=> !irq_req_o.err)
      else $error("error request without gated flag");

   a_ovr_gate: assert property (flag_ff[BIT_OVR] && en_ff[BIT_OVR] |=> irq_req_o.err)
      else $error("overrun error request missing");

   a_rx_gate: assert property (en_ff[BIT_RXF] == 1'b0 |=> !irq_req_o.rx)
      else $error("receive request while disabled");

   a_sens_none: assert property (en_ff[5:2] == 4'h0 && !flag_ff[BIT_CSC] |=> !flag_ff[BIT_CSC])
      else $error("status change flag set with no sensitivity");

   a_state_freeze: assert property (flag_ff[BIT_CSC] |=> $stable(rx_state_ff) && $stable(tx_state_ff))
      else $error("state bits moved while status change pending");

   a_busoff_code: assert property (!flag_ff[BIT_CSC] && transmit_error_level_i > BUSOFF_LIMIT
                                   |=> rx_state_ff == ST_BUSOFF && tx_state_ff == ST_BUSOFF)
      else $error("bus-off not encoded");

   a_rxf_set: assert property (evt_i.msg_stored |=> flag_ff[BIT_RXF])
      else $error("receive full flag not set");

   a_ovr_set: assert property (evt_i.overrun |=> flag_ff[BIT_OVR])
      else $error("overrun flag not set");

   a_csc_gate: assert property (flag_ff[BIT_CSC] && en_ff[BIT_CSC] |=> irq_req_o.err && irq_o)
      else $error("status change error request missing");

   a_rx_req: assert property (flag_ff[BIT_RXF] && en_ff[BIT_RXF] |=> irq_req_o.rx && irq_o)
      else $error("receive request missing");

   a_wake_off: assert property (!en_ff[BIT_WAKE] |=> !irq_req_o.wake)
      else $error("wake request while disabled");

   a_state_track: assert property (!flag_ff[BIT_CSC]
                                   |=> rx_state_ff == $past(rx_actual) && tx_state_ff == $past(tx_actual))
      else $error("state bits not tracking the error counters");

   sequence s_rx_err_to_busoff;
      en_ff[RSENS_HI:RSENS_LO] == SENS_ERR && !flag_ff[BIT_CSC] && rx_state_ff == ST_ERR && rx_actual == ST_BUSOFF;
   endsequence

   a_sens_err: assert property (s_rx_err_to_busoff |=> flag_ff[BIT_CSC])
      else $error("err level sensitivity missed a move into bus-off");

   a_tx_sens_bus: assert property (en_ff[TSENS_HI:TSENS_LO] == SENS_BUSOFF && !flag_ff[BIT_CSC]
                                   && tx_state_ff != ST_BUSOFF && tx_actual == ST_BUSOFF |=> flag_ff[BIT_CSC])
      else $error("bus-off sensitivity missed a transmitter change");

   a_bus_ack: assert property (s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not single cycle after request");

endmodule // crie_top
